// File: src/pmc_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - Ten power mode states covering ten chip modes
// - Every reset returns to normal run, regulator full
// - Full regulation in normal run, wait, stop
// - Wait and stop entered only on WFI
// - Normal wait: core sleeps, interrupt returns to run
// - Normal stop: clocks off, brown-out on, async wake
// - Reduced run: low regulator, slow flash, divided clocks
// - Reduced wait keeps reduced run, core-facing clock on
// - Reduced stop keeps low-power peripherals, SRAM retained
// - Leakage stop wakes only by wake unit to run
// - High leak stop keeps both SRAM banks powered
// - Mid and low leak stop power SRAM off
// - Low leak stop: oscillator off, brown-out optional
// - Leak stop recovery requests reset, wake flag set
// - Pin states held across all stop modes
module pmc_ctrl (
	// Clock and resets
	input  wire logic                       clk_i,
	input  wire logic                       reset_i,
	input  wire logic                       sys_rst_i,
	// Register port
	input  wire logic [pmc_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [pmc_pkg::DATA_W-1:0] wdata_i,
	input  wire logic                       wr_i,
	input  wire logic                       rd_i,
	output logic      [pmc_pkg::DATA_W-1:0] rdata_o,
	// Core and wake sources
	input  wire logic                       wfi_i,
	input  wire logic                       irq_pend_i,
	input  wire logic                       async_wake_irq_ctrl_wake_i,
	input  wire logic                       wake_unit_i,
	// Power controls and status
	output pmc_pkg::pmc_pwr_s               pwr_o,
	output pmc_pkg::pmc_mode_e              mode_o,
	output logic                            sleeping_o,
	output logic                            wake_reset_req_o,
	output logic                            wake_flag_o
);

	pmc_pkg::pmc_mode_e           mode_ff;
	pmc_pkg::pmc_mode_e           nxt_mode;
	pmc_pkg::pmc_ctrl_s           ctrl_ff;
	pmc_pkg::pmc_pwr_s            pwr_ff;
	logic [pmc_pkg::SYNC_W-1:0]   wake_sync;
	logic                         async_wake_irq_ctrl_s;
	logic                         wake_s;
	logic                         wrst_ff;
	logic                         wuf_ff;
	logic                         wreq_ff;
	logic                         leak_wake;
	logic                         clr_wrst;
	logic                         clr_wuf;
	logic [pmc_pkg::DATA_W-1:0]   rdata_ff;

	// Wake sources come from unclocked units, so synchronise them
	pmc_sync u_sync (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.async_i ({wake_unit_i, async_wake_irq_ctrl_wake_i}),
		.sync_o  (wake_sync)
	);
	assign async_wake_irq_ctrl_s = wake_sync[pmc_pkg::SYNC_ASYNC_WAKE_IRQ_CTRL];
	assign wake_s = wake_sync[pmc_pkg::SYNC_WAKE];

	// Address match, shared by the write and read decoders
	function automatic logic hit(input logic [pmc_pkg::ADDR_W-1:0] a,
			input logic [pmc_pkg::ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	// Target of a WFI from the current run mode
	function automatic pmc_pkg::pmc_mode_e sel_mode(
			input pmc_pkg::pmc_ctrl_s c, input logic reduced);
		sel_mode = reduced ? pmc_pkg::MODE_RSTOP : pmc_pkg::MODE_STOP;
		if (!c.deep) begin
			sel_mode = reduced ? pmc_pkg::MODE_RWAIT : pmc_pkg::MODE_WAIT;
		end else begin
			case (c.stop_sel)
				pmc_pkg::SEL_RSTOP:   sel_mode = pmc_pkg::MODE_RSTOP;
				pmc_pkg::SEL_LRS:     sel_mode = pmc_pkg::MODE_LRS;
				pmc_pkg::SEL_LK_HIGH: sel_mode = pmc_pkg::MODE_LK_HIGH;
				pmc_pkg::SEL_LK_MID:  sel_mode = pmc_pkg::MODE_LK_MID;
				pmc_pkg::SEL_LK_LOW:  sel_mode = pmc_pkg::MODE_LK_LOW;
				default: ;
			endcase
		end
	endfunction : sel_mode

	// Power control pattern of each mode
	function automatic pmc_pkg::pmc_pwr_s pwr_decode(
			input pmc_pkg::pmc_mode_e m, input pmc_pkg::pmc_ctrl_s c);
		pmc_pkg::pmc_pwr_s p;
		p = '{core_clk_en: 1'b1, core_facing_clock_en: 1'b1, periph_clk_en: 1'b1,
			osc_cmp_en: 1'b1, lp_periph_en: 1'b1, opt_periph_en: 1'b1,
			reg_full: 1'b1, bdet_en: 1'b1, flash_slow: 1'b0,
			nested_irq_ctrl_en: 1'b1, async_wake_irq_ctrl_en: 1'b0, wake_unit_en: 1'b0,
			sram_pwr: 1'b1, sram_ret: 1'b1, lpo_en: 1'b1, io_hold: 1'b0,
			core_div: pmc_pkg::DIV_ONE, bus_div: pmc_pkg::DIV_ONE,
			flash_div: pmc_pkg::DIV_ONE};
		// Reduced-power family: low regulator, no brown-out, slow clocks
		if (m inside {pmc_pkg::MODE_RRUN, pmc_pkg::MODE_RWAIT,
				pmc_pkg::MODE_RSTOP}) begin
			p.reg_full   = 1'b0;
			p.bdet_en    = 1'b0;
			p.flash_slow = 1'b1;
			p.core_div   = pmc_pkg::CORE_DIV_RED;
			p.bus_div    = pmc_pkg::BUS_DIV_RED;
			p.flash_div  = pmc_pkg::FLASH_DIV_RED;
		end
		// Every deep sleep stops the core side and freezes the pins
		if (!(m inside {pmc_pkg::MODE_RUN, pmc_pkg::MODE_RRUN,
				pmc_pkg::MODE_WAIT, pmc_pkg::MODE_RWAIT})) begin
			p.core_clk_en   = 1'b0;
			p.core_facing_clock_en       = 1'b0;
			p.periph_clk_en = 1'b0;
			p.opt_periph_en = 1'b0;
			p.nested_irq_ctrl_en       = 1'b0;
			p.io_hold       = 1'b1;
		end
		case (m)
			pmc_pkg::MODE_WAIT,
			pmc_pkg::MODE_RWAIT: begin
				p.core_clk_en = 1'b0;
			end
			pmc_pkg::MODE_STOP: begin
				p.osc_cmp_en   = 1'b0;
				p.lp_periph_en = 1'b0;
				p.async_wake_irq_ctrl_en      = 1'b1;
			end
			pmc_pkg::MODE_RSTOP: begin
				p.opt_periph_en = c.opt_periph;
				p.async_wake_irq_ctrl_en       = 1'b1;
			end
			pmc_pkg::MODE_LRS,
			pmc_pkg::MODE_LK_HIGH: begin
				p.reg_full     = 1'b0;
				p.bdet_en      = 1'b0;
				p.wake_unit_en = 1'b1;
			end
			pmc_pkg::MODE_LK_MID,
			pmc_pkg::MODE_LK_LOW: begin
				p.reg_full     = 1'b0;
				p.bdet_en      = (m == pmc_pkg::MODE_LK_LOW) && c.por_bdet;
				p.wake_unit_en = 1'b1;
				p.sram_pwr     = 1'b0;
				p.sram_ret     = 1'b0;
				if (m == pmc_pkg::MODE_LK_LOW) begin
					p.lpo_en     = 1'b0;
					p.osc_cmp_en = 1'b0;
				end
			end
			default: ;
		endcase
		return p;
	endfunction : pwr_decode

	// Control register; any reset restores the defaults
	always_ff @(posedge clk_i) begin
		if (reset_i || sys_rst_i) begin
			ctrl_ff <= pmc_pkg::CTRL_RST;
		end else if (wr_i && hit(addr_i, pmc_pkg::CTRL_OFS)) begin
			ctrl_ff <= wdata_i[pmc_pkg::CTRL_W-1:0];
		end
	end

	// Mode sequencer
	always_comb begin
		nxt_mode = mode_ff;
		case (mode_ff)
			pmc_pkg::MODE_RUN: begin
				if (wfi_i) begin
					nxt_mode = sel_mode(ctrl_ff, 1'b0);
				end else if (ctrl_ff.rrun) begin
					nxt_mode = pmc_pkg::MODE_RRUN;
				end
			end
			pmc_pkg::MODE_RRUN: begin
				if (wfi_i) begin
					nxt_mode = sel_mode(ctrl_ff, 1'b1);
				end else if (!ctrl_ff.rrun) begin
					nxt_mode = pmc_pkg::MODE_RUN;
				end
			end
			pmc_pkg::MODE_WAIT: begin
				if (irq_pend_i) nxt_mode = pmc_pkg::MODE_RUN;
			end
			pmc_pkg::MODE_RWAIT: begin
				if (irq_pend_i) nxt_mode = pmc_pkg::MODE_RRUN;
			end
			pmc_pkg::MODE_STOP: begin
				if (async_wake_irq_ctrl_s) nxt_mode = pmc_pkg::MODE_RUN;
			end
			pmc_pkg::MODE_RSTOP: begin
				if (async_wake_irq_ctrl_s) begin
					nxt_mode = ctrl_ff.rrun ? pmc_pkg::MODE_RRUN
						: pmc_pkg::MODE_RUN;
				end
			end
			// Only the wake unit ends leakage stops; its interrupt must
			// stay unmasked or the core never finishes the exit
			pmc_pkg::MODE_LRS,
			pmc_pkg::MODE_LK_HIGH,
			pmc_pkg::MODE_LK_MID,
			pmc_pkg::MODE_LK_LOW: begin
				if (wake_s) nxt_mode = pmc_pkg::MODE_RUN;
			end
			default: nxt_mode = pmc_pkg::MODE_RUN;
		endcase
		if (sys_rst_i) nxt_mode = pmc_pkg::MODE_RUN;
	end

	// Mode state and its registered power pattern
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			mode_ff <= pmc_pkg::MODE_RUN;
			pwr_ff  <= pwr_decode(pmc_pkg::MODE_RUN, pmc_pkg::CTRL_RST);
		end else begin
			mode_ff <= nxt_mode;
			pwr_ff  <= pwr_decode(nxt_mode, ctrl_ff);
		end
	end

	// Leak-stop wake: go through the reset flow, keep the flags
	assign leak_wake = !sys_rst_i && wake_s &&
		(mode_ff inside {pmc_pkg::MODE_LK_HIGH, pmc_pkg::MODE_LK_MID,
		pmc_pkg::MODE_LK_LOW});
	assign clr_wrst = wr_i && hit(addr_i, pmc_pkg::STAT_OFS) &&
		wdata_i[pmc_pkg::STAT_WRST_BIT];
	assign clr_wuf = wr_i && hit(addr_i, pmc_pkg::STAT_OFS) &&
		wdata_i[pmc_pkg::STAT_WUF_BIT];

	// Flags survive the system reset they trigger; set beats clear
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wrst_ff <= 1'b0;
			wuf_ff  <= 1'b0;
			wreq_ff <= 1'b0;
		end else begin
			wreq_ff <= leak_wake;
			wrst_ff <= leak_wake || (wrst_ff && !clr_wrst);
			wuf_ff  <= leak_wake || (wuf_ff && !clr_wuf);
		end
	end

	// Read data stands one cycle after the strobe; unmapped read zero
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= '0;
			if (rd_i && hit(addr_i, pmc_pkg::CTRL_OFS)) begin
				rdata_ff[pmc_pkg::CTRL_W-1:0] <= ctrl_ff;
			end else if (rd_i && hit(addr_i, pmc_pkg::STAT_OFS)) begin
				rdata_ff[pmc_pkg::STAT_MODE_LSB+:4] <= mode_ff;
				rdata_ff[pmc_pkg::STAT_WRST_BIT]     <= wrst_ff;
				rdata_ff[pmc_pkg::STAT_WUF_BIT]      <= wuf_ff;
			end
		end
	end

	assign rdata_o          = rdata_ff;
	assign pwr_o            = pwr_ff;
	assign mode_o           = mode_ff;
	assign sleeping_o       = !(mode_ff inside {pmc_pkg::MODE_RUN,
		pmc_pkg::MODE_RRUN});
	assign wake_reset_req_o = wreq_ff;
	assign wake_flag_o      = wuf_ff;

	// Checks on the sequencer
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	property p_legal_mode;
		mode_ff inside {pmc_pkg::MODE_RUN, pmc_pkg::MODE_WAIT,
			pmc_pkg::MODE_STOP, pmc_pkg::MODE_RRUN, pmc_pkg::MODE_RWAIT,
			pmc_pkg::MODE_RSTOP, pmc_pkg::MODE_LRS, pmc_pkg::MODE_LK_HIGH,
			pmc_pkg::MODE_LK_MID, pmc_pkg::MODE_LK_LOW};
	endproperty
	a_legal_mode: assert property (p_legal_mode)
		else $error("illegal power mode");

	property p_reset_run;
		sys_rst_i |=> mode_ff == pmc_pkg::MODE_RUN && pwr_o.reg_full;
	endproperty
	a_reset_run: assert property (p_reset_run)
		else $error("reset did not return to normal run");

	property p_full_reg;
		mode_ff inside {pmc_pkg::MODE_RUN, pmc_pkg::MODE_WAIT,
			pmc_pkg::MODE_STOP} |-> pwr_o.reg_full;
	endproperty
	a_full_reg: assert property (p_full_reg)
		else $error("normal mode without full regulation");

	property p_sleep_needs_wfi;
		mode_ff inside {pmc_pkg::MODE_RUN, pmc_pkg::MODE_RRUN} && !wfi_i
			|=> !sleeping_o;
	endproperty
	a_sleep_needs_wfi: assert property (p_sleep_needs_wfi)
		else $error("sleep entered without wfi");

	property p_wait_wake;
		mode_ff == pmc_pkg::MODE_WAIT && irq_pend_i && !sys_rst_i
			|=> mode_ff == pmc_pkg::MODE_RUN ##1 pwr_o.core_clk_en[*2];
	endproperty
	a_wait_wake: assert property (p_wait_wake)
		else $error("normal wait did not wake to run");

	property p_stop_pwr;
		mode_ff == pmc_pkg::MODE_STOP |-> !pwr_o.periph_clk_en &&
			pwr_o.bdet_en && !pwr_o.nested_irq_ctrl_en && pwr_o.async_wake_irq_ctrl_en;
	endproperty
	a_stop_pwr: assert property (p_stop_pwr)
		else $error("normal stop controls wrong");

	property p_rrun_pwr;
		mode_ff == pmc_pkg::MODE_RRUN |-> !pwr_o.reg_full &&
			!pwr_o.bdet_en && pwr_o.flash_slow &&
			pwr_o.bus_div == pmc_pkg::BUS_DIV_RED;
	endproperty
	a_rrun_pwr: assert property (p_rrun_pwr)
		else $error("reduced run controls wrong");

	property p_rwait_pwr;
		mode_ff == pmc_pkg::MODE_RWAIT |-> pwr_o.core_facing_clock_en &&
			!pwr_o.core_clk_en && !pwr_o.reg_full;
	endproperty
	a_rwait_pwr: assert property (p_rwait_pwr)
		else $error("reduced wait controls wrong");

	property p_rstop_pwr;
		mode_ff == pmc_pkg::MODE_RSTOP |-> pwr_o.lp_periph_en &&
			pwr_o.osc_cmp_en && pwr_o.sram_ret && !pwr_o.bdet_en;
	endproperty
	a_rstop_pwr: assert property (p_rstop_pwr)
		else $error("reduced stop controls wrong");

	property p_lrs_wake;
		mode_ff == pmc_pkg::MODE_LRS && !wake_s && !sys_rst_i
			|=> mode_ff == pmc_pkg::MODE_LRS;
	endproperty
	a_lrs_wake: assert property (p_lrs_wake)
		else $error("leakage stop left without wake unit");

	property p_sram_levels;
		(mode_ff == pmc_pkg::MODE_LK_HIGH |-> pwr_o.sram_pwr) and
		(mode_ff inside {pmc_pkg::MODE_LK_MID, pmc_pkg::MODE_LK_LOW}
			|-> !pwr_o.sram_pwr);
	endproperty
	a_sram_levels: assert property (p_sram_levels)
		else $error("leak stop sram power wrong");

	property p_low_lpo;
		mode_ff == pmc_pkg::MODE_LK_LOW |-> !pwr_o.lpo_en &&
			pwr_o.bdet_en == ctrl_ff.por_bdet;
	endproperty
	a_low_lpo: assert property (p_low_lpo)
		else $error("low leak stop oscillator wrong");

	property p_leak_recover;
		leak_wake |=> wake_reset_req_o && wake_flag_o &&
			mode_ff == pmc_pkg::MODE_RUN ##1 !wake_reset_req_o;
	endproperty
	a_leak_recover: assert property (p_leak_recover)
		else $error("leak stop recovery wrong");

	property p_io_hold;
		sleeping_o && !(mode_ff inside {pmc_pkg::MODE_WAIT,
			pmc_pkg::MODE_RWAIT}) |-> pwr_o.io_hold;
	endproperty
	a_io_hold: assert property (p_io_hold)
		else $error("pins not held in stop");

	property p_select;
		mode_ff == pmc_pkg::MODE_RUN && wfi_i && !sys_rst_i &&
			ctrl_ff.deep && ctrl_ff.stop_sel == pmc_pkg::SEL_LK_MID
			|=> mode_ff == pmc_pkg::MODE_LK_MID;
	endproperty
	a_select: assert property (p_select)
		else $error("wfi target mismatch");

	property p_wrst_keep;
		wrst_ff && sys_rst_i && !clr_wrst |=> wrst_ff;
	endproperty
	a_wrst_keep: assert property (p_wrst_keep)
		else $error("wake reset flag lost");

	c_wait_cycle: cover property (mode_ff == pmc_pkg::MODE_WAIT
		##1 mode_ff == pmc_pkg::MODE_RUN);
	c_rstop_wake: cover property (mode_ff == pmc_pkg::MODE_RSTOP
		##1 mode_ff == pmc_pkg::MODE_RRUN);
	c_leak_wake: cover property (leak_wake ##1 wake_reset_req_o);
	c_lrs_wake: cover property (mode_ff == pmc_pkg::MODE_LRS
		##1 mode_ff == pmc_pkg::MODE_RUN);

endmodule : pmc_ctrl

// File: include/pmc_pkg.sv
package pmc_pkg;

	// Power modes, Gray coded along run -> wait/stop -> deeper stops
	typedef enum logic [3:0] {
		MODE_RUN      = 4'h0,
		MODE_WAIT     = 4'h1,
		MODE_STOP     = 4'h3,
		MODE_RRUN     = 4'h2,
		MODE_RWAIT    = 4'h6,
		MODE_RSTOP    = 4'h7,
		MODE_LRS      = 4'h5,
		MODE_LK_HIGH  = 4'h4,
		MODE_LK_MID   = 4'hC,
		MODE_LK_LOW   = 4'hD
	} pmc_mode_e;

	// Register bus geometry
	localparam int          ADDR_W   = 4;
	localparam int          DATA_W   = 32;
	localparam logic [3:0]  CTRL_OFS = 4'h0;
	localparam logic [3:0]  STAT_OFS = 4'h4;

	// Control register field positions
	localparam int CTRL_RRUN_BIT  = 0;
	localparam int CTRL_DEEP_BIT  = 1;
	localparam int CTRL_SEL_LSB   = 2;
	localparam int CTRL_PORBD_BIT = 5;
	localparam int CTRL_OPTP_BIT  = 6;
	localparam int CTRL_W         = 7;

	// Status register field positions
	localparam int STAT_MODE_LSB = 0;
	localparam int STAT_WRST_BIT = 8;
	localparam int STAT_WUF_BIT  = 9;

	// Stop level select codes
	localparam logic [2:0] SEL_STOP    = 3'h0;
	localparam logic [2:0] SEL_RSTOP   = 3'h1;
	localparam logic [2:0] SEL_LRS     = 3'h2;
	localparam logic [2:0] SEL_LK_HIGH = 3'h3;
	localparam logic [2:0] SEL_LK_MID  = 3'h4;
	localparam logic [2:0] SEL_LK_LOW  = 3'h5;

	// Reset values
	localparam logic [6:0] CTRL_RST = 7'h00;

	// Synchroniser lanes
	localparam int SYNC_W    = 2;
	localparam int SYNC_ASYNC_WAKE_IRQ_CTRL = 0;
	localparam int SYNC_WAKE = 1;

	// Clock rates and the dividers derived for reduced-power run
	localparam int SYS_CLK_HZ         = 100_000_000;
	localparam int REDUCED_CORE_HZ    = 4_000_000;
	localparam int REDUCED_BUS_MAX_HZ = 800_000;
	localparam int REDUCED_FLASH_HZ   = 1_000_000;
	localparam logic [7:0] DIV_ONE    = 8'h01;
	localparam logic [7:0] CORE_DIV_RED =
		8'(SYS_CLK_HZ / REDUCED_CORE_HZ);
	localparam logic [7:0] BUS_DIV_RED =
		8'(SYS_CLK_HZ / REDUCED_BUS_MAX_HZ + 1);
	localparam logic [7:0] FLASH_DIV_RED =
		8'(SYS_CLK_HZ / REDUCED_FLASH_HZ);

	// Software control settings
	typedef struct packed {
		logic       opt_periph;
		logic       por_bdet;
		logic [2:0] stop_sel;
		logic       deep;
		logic       rrun;
	} pmc_ctrl_s;

	// Power domain controls driven to the chip
	typedef struct packed {
		logic       core_clk_en;
		logic       core_facing_clock_en;
		logic       periph_clk_en;
		logic       osc_cmp_en;
		logic       lp_periph_en;
		logic       opt_periph_en;
		logic       reg_full;
		logic       bdet_en;
		logic       flash_slow;
		logic       nested_irq_ctrl_en;
		logic       async_wake_irq_ctrl_en;
		logic       wake_unit_en;
		logic       sram_pwr;
		logic       sram_ret;
		logic       lpo_en;
		logic       io_hold;
		logic [7:0] core_div;
		logic [7:0] bus_div;
		logic [7:0] flash_div;
	} pmc_pwr_s;

endpackage : pmc_pkg

// File: src/pmc_sync.sv
`timescale 1ns/1ps
module pmc_sync (
	// Clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     reset_i,
	// Asynchronous levels in, synchronous levels out
	input  wire logic [pmc_pkg::SYNC_W-1:0] async_i,
	output logic      [pmc_pkg::SYNC_W-1:0] sync_o
);

	logic [pmc_pkg::SYNC_W-1:0] meta_ff;
	logic [pmc_pkg::SYNC_W-1:0] sync_ff;

	// Two flops per lane; the first is read by the second only
	genvar g;
	generate
		for (g = 0; g < pmc_pkg::SYNC_W; g++) begin : g_lane
			always_ff @(posedge clk_i) begin
				if (reset_i) begin
					meta_ff[g] <= 1'b0;
					sync_ff[g] <= 1'b0;
				end else begin
					meta_ff[g] <= async_i[g];
					sync_ff[g] <= meta_ff[g];
				end
			end
		end
	endgenerate

	assign sync_o = sync_ff;

endmodule : pmc_sync

// File: sim/pmc_core_model.sv
`timescale 1ns/1ps
module pmc_core_model (
	// Clock
	input  wire logic clk_i,
	// Sleep request and wake levels
	output logic      wfi_o,
	output logic      irq_pend_o,
	output logic      async_wake_irq_ctrl_wake_o,
	output logic      wake_unit_o
);
	// All lines quiet from time zero
	initial begin
		wfi_o       = 1'b0;
		irq_pend_o  = 1'b0;
		async_wake_irq_ctrl_wake_o = 1'b0;
		wake_unit_o = 1'b0;
	end

	// One-cycle sleep request, the way the core issues WFI
	task automatic sleep();
		@(posedge clk_i);
		wfi_o <= 1'b1;
		@(posedge clk_i);
		wfi_o <= 1'b0;
	endtask : sleep

	// One-cycle pending interrupt pulse
	task automatic irq();
		@(posedge clk_i);
		irq_pend_o <= 1'b1;
		@(posedge clk_i);
		irq_pend_o <= 1'b0;
	endtask : irq

	// Wake levels move on the edge like every other input; the design's
	// synchroniser absorbs their phase, so the latency stays fixed
	task automatic set_wake(input logic unit, input logic lvl);
		@(posedge clk_i);
		if (unit)
			wake_unit_o <= lvl;
		else
			async_wake_irq_ctrl_wake_o <= lvl;
	endtask : set_wake
endmodule : pmc_core_model

// File: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic                         clk_i;
	logic                         reset_i;
	logic                         sys_rst_i;
	logic [pmc_pkg::ADDR_W-1:0]   addr_i;
	logic [pmc_pkg::DATA_W-1:0]   wdata_i;
	logic                         wr_i;
	logic                         rd_i;
	logic [pmc_pkg::DATA_W-1:0]   rdata_o;
	logic                         wfi;
	logic                         irq_pend;
	logic                         async_wake_irq_ctrl_wake;
	logic                         wake_unit;
	pmc_pkg::pmc_pwr_s            pwr_o;
	pmc_pkg::pmc_mode_e           mode_o;
	logic                         sleeping_o;
	logic                         wrr_o;
	logic                         wflag_o;
	pmc_pkg::pmc_pwr_s            run_pwr;
	int                           n_fail;
	int                           n_tests;

	pmc_ctrl pmc_ctrl_inst (
		.clk_i(clk_i), .reset_i(reset_i), .sys_rst_i(sys_rst_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .wfi_i(wfi), .irq_pend_i(irq_pend),
		.async_wake_irq_ctrl_wake_i(async_wake_irq_ctrl_wake), .wake_unit_i(wake_unit), .pwr_o(pwr_o),
		.mode_o(mode_o), .sleeping_o(sleeping_o),
		.wake_reset_req_o(wrr_o), .wake_flag_o(wflag_o)
	);

	pmc_core_model pmc_core_model_inst (
		.clk_i(clk_i), .wfi_o(wfi), .irq_pend_o(irq_pend),
		.async_wake_irq_ctrl_wake_o(async_wake_irq_ctrl_wake), .wake_unit_o(wake_unit)
	);

	// 100 MHz clock
	initial clk_i = 1'b0;
	always #5 clk_i = ~clk_i;

	// Compare any design value, unknowns never match
	task automatic chk(input logic [63:0] got, input logic [63:0] exp,
			input string what);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: %s got %0h exp %0h", $time, what, got,
				exp);
		end
	endtask : chk

	// Single-cycle register write
	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i    <= 1'b0;
	endtask : reg_wr

	// Read strobe, data sampled in the following cycle only
	task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp,
			input string what);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i   <= 1'b0;
		#1;
		chk(64'(rdata_o), 64'(exp), what);
	endtask : reg_rd

	// Count edges until the mode moves, bounded
	task automatic wait_change(output int n);
		pmc_pkg::pmc_mode_e m0;
		m0 = mode_o;
		n  = 0;
		while (mode_o === m0 && n < 10) begin
			@(posedge clk_i);
			#1;
			n++;
		end
	endtask : wait_change

	// Mode plus sleep indication after a request
	task automatic chk_mode(input pmc_pkg::pmc_mode_e m, input logic s);
		chk(64'(mode_o), 64'(m), "mode");
		chk(64'(sleeping_o), 64'(s), "sleeping");
	endtask : chk_mode

	task automatic results();
		$display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results

	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#200000;
		n_fail++;
		results();
	end

	initial begin
		int n;
		logic [2:0] sel_tab [4];
		pmc_pkg::pmc_mode_e mode_tab [4];
		sel_tab  = '{pmc_pkg::SEL_LRS, pmc_pkg::SEL_LK_HIGH,
			pmc_pkg::SEL_LK_MID, pmc_pkg::SEL_LK_LOW};
		mode_tab = '{pmc_pkg::MODE_LRS, pmc_pkg::MODE_LK_HIGH,
			pmc_pkg::MODE_LK_MID, pmc_pkg::MODE_LK_LOW};
		n_fail    = 0;
		n_tests   = 0;
		reset_i   = 1'b1;
		sys_rst_i = 1'b0;
		addr_i    = '0;
		wdata_i   = '0;
		wr_i      = 1'b0;
		rd_i      = 1'b0;
		run_pwr   = '1;
		run_pwr.flash_slow   = 1'b0;
		run_pwr.async_wake_irq_ctrl_en      = 1'b0;
		run_pwr.wake_unit_en = 1'b0;
		run_pwr.io_hold      = 1'b0;
		run_pwr.core_div     = pmc_pkg::DIV_ONE;
		run_pwr.bus_div      = pmc_pkg::DIV_ONE;
		run_pwr.flash_div    = pmc_pkg::DIV_ONE;
		repeat (20) @(posedge clk_i);
		reset_i <= 1'b0;
		#1;
		chk_mode(pmc_pkg::MODE_RUN, 1'b0);
		chk(64'(pwr_o), 64'(run_pwr), "run controls");
		reg_wr(pmc_pkg::CTRL_OFS, 32'hFFFF_FF7C);
		reg_rd(pmc_pkg::CTRL_OFS, 32'h7C, "ctrl");
		reg_rd(4'h8, 32'h0, "unmapped");
		$display("Test registers done");

		// Normal wait: WFI without deep, a second WFI is ignored
		reg_wr(pmc_pkg::CTRL_OFS, 32'h0);
		pmc_core_model_inst.sleep();
		#1;
		chk_mode(pmc_pkg::MODE_WAIT, 1'b1);
		chk(64'(pwr_o.periph_clk_en), 64'h1, "wait clocks");
		pmc_core_model_inst.sleep();
		reg_rd(pmc_pkg::STAT_OFS, 32'h1, "wait status");
		pmc_core_model_inst.irq();
		#1;
		chk_mode(pmc_pkg::MODE_RUN, 1'b0);
		$display("Test wait done");

		// Normal stop: interrupt and wake unit ignored, async wake in 3
		reg_wr(pmc_pkg::CTRL_OFS, 32'h2);
		pmc_core_model_inst.sleep();
		#1;
		chk_mode(pmc_pkg::MODE_STOP, 1'b1);
		chk(64'(pwr_o.periph_clk_en), 64'h0, "stop clocks");
		chk(64'(pwr_o.bdet_en), 64'h1, "stop brown-out");
		chk(64'(pwr_o.reg_full), 64'h1, "stop regulator");
		chk(64'(pwr_o.nested_irq_ctrl_en), 64'h0, "stop nested_irq_ctrl");
		chk(64'(pwr_o.async_wake_irq_ctrl_en), 64'h1, "stop async_wake_irq_ctrl");
		chk(64'(pwr_o.io_hold), 64'h1, "stop pins");
		pmc_core_model_inst.irq();
		pmc_core_model_inst.set_wake(1'b1, 1'b1);
		repeat (5) @(posedge clk_i);
		#1;
		chk_mode(pmc_pkg::MODE_STOP, 1'b1);
		pmc_core_model_inst.set_wake(1'b1, 1'b0);
		pmc_core_model_inst.set_wake(1'b0, 1'b1);
		wait_change(n);
		chk(64'(n), 64'h3, "async_wake_irq_ctrl latency");
		chk_mode(pmc_pkg::MODE_RUN, 1'b0);
		pmc_core_model_inst.set_wake(1'b0, 1'b0);
		$display("Test stop done");

		// Reduced run, wait and stop
		reg_wr(pmc_pkg::CTRL_OFS, 32'h1);
		repeat (2) @(posedge clk_i);
		#1;
		chk_mode(pmc_pkg::MODE_RRUN, 1'b0);
		chk(64'(pwr_o.reg_full), 64'h0, "rrun regulator");
		chk(64'(pwr_o.bdet_en), 64'h0, "rrun brown-out");
		chk(64'(pwr_o.flash_slow), 64'h1, "rrun flash");
		chk(64'({pwr_o.core_div, pwr_o.bus_div, pwr_o.flash_div}),
			64'({8'd25, 8'd126, 8'd100}), "rrun dividers");
		pmc_core_model_inst.sleep();
		#1;
		chk_mode(pmc_pkg::MODE_RWAIT, 1'b1);
		chk(64'({pwr_o.core_facing_clock_en, pwr_o.reg_full}), 64'h2, "rwait");
		pmc_core_model_inst.irq();
		#1;
		chk_mode(pmc_pkg::MODE_RRUN, 1'b0);
		reg_wr(pmc_pkg::CTRL_OFS, 32'h47);
		pmc_core_model_inst.sleep();
		#1;
		chk_mode(pmc_pkg::MODE_RSTOP, 1'b1);
		chk(64'({pwr_o.osc_cmp_en, pwr_o.lp_periph_en, pwr_o.opt_periph_en,
			pwr_o.periph_clk_en, pwr_o.bdet_en, pwr_o.sram_ret,
			pwr_o.io_hold}), 64'h73, "rstop controls");
		pmc_core_model_inst.set_wake(1'b0, 1'b1);
		wait_change(n);
		chk_mode(pmc_pkg::MODE_RRUN, 1'b0);
		pmc_core_model_inst.set_wake(1'b0, 1'b0);
		$display("Test reduced done");

		// Leakage stops: wake unit only, flags and reset request
		for (int i = 0; i < 4; i++) begin
			reg_wr(pmc_pkg::CTRL_OFS,
				{26'h0, (i == 3), sel_tab[i], 2'b10});
			pmc_core_model_inst.sleep();
			#1;
			chk_mode(mode_tab[i], 1'b1);
			chk(64'(pwr_o.io_hold), 64'h1, "leak pins");
			chk(64'(pwr_o.sram_pwr), 64'(i < 2), "sram power");
			chk(64'(pwr_o.sram_ret), 64'(i < 2), "sram keep");
			chk(64'(pwr_o.lpo_en), 64'(i != 3), "leak lpo");
			chk(64'(pwr_o.bdet_en), 64'(i == 3), "leak bdet");
			pmc_core_model_inst.set_wake(1'b0, 1'b1);
			repeat (5) @(posedge clk_i);
			#1;
			chk_mode(mode_tab[i], 1'b1);
			pmc_core_model_inst.set_wake(1'b0, 1'b0);
			pmc_core_model_inst.set_wake(1'b1, 1'b1);
			wait_change(n);
			chk(64'(n), 64'h3, "wake latency");
			chk_mode(pmc_pkg::MODE_RUN, 1'b0);
			chk(64'({wrr_o, wflag_o}), 64'(i > 0 ? 3 : 0), "wake");
			@(posedge clk_i);
			#1;
			chk(64'(wrr_o), 64'h0, "request pulse");
			pmc_core_model_inst.set_wake(1'b1, 1'b0);
			@(posedge clk_i);
			sys_rst_i <= 1'b1;
			@(posedge clk_i);
			sys_rst_i <= 1'b0;
			reg_rd(pmc_pkg::STAT_OFS, i > 0 ? 32'h300 : 32'h0, "flags");
			reg_rd(pmc_pkg::CTRL_OFS, 32'h0, "ctrl cleared");
			reg_wr(pmc_pkg::STAT_OFS, 32'h300);
			reg_rd(pmc_pkg::STAT_OFS, 32'h0, "flags cleared");
		end
		$display("Test leakage done");

		// Power-on reset in mid-stop; select code 7 falls back to stop
		reg_wr(pmc_pkg::CTRL_OFS, 32'h1E);
		pmc_core_model_inst.sleep();
		#1;
		chk_mode(pmc_pkg::MODE_STOP, 1'b1);
		@(posedge clk_i);
		reset_i <= 1'b1;
		@(posedge clk_i);
		reset_i <= 1'b0;
		#1;
		chk_mode(pmc_pkg::MODE_RUN, 1'b0);
		chk(64'(pwr_o), 64'(run_pwr), "reset controls");
		$display("Test reset done");
		results();
	end
endmodule : testbench
